// ---- rtl/ppl_pkg.sv ----
// Shared constants, register map and types for the port pin and address strobe block
package ppl_pkg;
  // Timing: clock_in is twice the crystal rate, so half crystal periods are whole cycles
  localparam int unsigned CLK_HZ           = 10_000_000;  // Rate of clock_in
  localparam int unsigned CLK_PER_XTAL     = 2;           // clock_in cycles per crystal period
  localparam int unsigned XTAL_HZ          = CLK_HZ / CLK_PER_XTAL;
  localparam int unsigned STROBE_HI_HALVES = 3;           // 1.5 crystal periods, in half periods
  localparam int unsigned STROBE_PERIOD_X  = 4;           // Strobe period in crystal periods
  localparam int unsigned STROBE_HI_CLKS   = (STROBE_HI_HALVES * CLK_PER_XTAL) / 2;
  localparam int unsigned STROBE_PER_CLKS  = STROBE_PERIOD_X * CLK_PER_XTAL;
  localparam logic [2:0]  PHASE_LAST       = 3'(STROBE_PER_CLKS - 1);
  localparam logic [2:0]  PHASE_HI_LAST    = 3'(STROBE_HI_CLKS - 1);

  // Register byte offsets on the plain register port
  localparam logic [7:0] OFS_POWER_MGMT = 8'h00;  // power_mgmt_reg
  localparam logic [7:0] OFS_P1_LATCH   = 8'h01;  // Second port output latch
  localparam logic [7:0] OFS_P1_PINS    = 8'h02;  // Second port pin levels, read only
  localparam logic [7:0] OFS_P0_LATCH   = 8'h03;  // Low port output latch
  localparam logic [7:0] OFS_P0_PINS    = 8'h04;  // Low port pin levels, read only
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h05;  // Sticky edge flags, read only
  localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h06;  // Write one to clear, write only
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h07;  // Interrupt enable mask

  // Field positions and reset values
  localparam int unsigned BIT_STROBE_DISABLE = 2;      // strobe_disable_bit in power_mgmt_reg
  localparam int unsigned BIT_T2_IO          = 0;      // timer2_ext_io
  localparam int unsigned BIT_T2_TRIG        = 1;      // timer2_capture_trigger
  localparam int unsigned BIT_SER_RX         = 2;      // serial1_receive_in
  localparam int unsigned BIT_SER_TX         = 3;      // serial1_transmit_out
  localparam int unsigned BIT_IRQ_RISE_A     = 4;      // ext_irq_rise_a
  localparam int unsigned BIT_IRQ_FALL_A     = 5;      // ext_irq_fall_a
  localparam int unsigned BIT_IRQ_RISE_B     = 6;      // ext_irq_rise_b
  localparam int unsigned BIT_IRQ_FALL_B     = 7;      // ext_irq_fall_b
  localparam logic [7:0]  PORT_LATCH_RST     = 8'hFF;  // Both port latches reset to ones
  localparam logic [7:0]  BYTE_ZERO          = 8'h00;
  localparam logic [7:0]  BYTE_ONES          = 8'hFF;
  localparam logic [3:0]  IRQ_ZERO           = 4'h0;

  // What the low port is doing in the current cycle
  typedef enum logic [1:0]
  {
    PPL_GPIO  = 2'b00,  // Open-drain general port
    PPL_ADDR  = 2'b01,  // Address low byte driven while strobe is high
    PPL_WDATA = 2'b10,  // Write data driven
    PPL_RDATA = 2'b11   // Released, external device drives read data
  } ppl_bus_mode_type;

  // External access request from the core
  typedef struct packed
  {
    logic       write;     // One for a write, zero for a read
    logic [7:0] addr_low;  // Low address byte
    logic [7:0] wdata;     // Write data
  } ppl_ext_req_type;
endpackage

// ---- rtl/ppl_port_pins.sv ----
// Address latch strobe, multiplexed low port and quasi-bidirectional second port
//
// How it works
// (RULE1) Strobe high 1.5 crystal periods, every four
// (RULE2) Strobe held high during reset
// (RULE3) Disable bit set holds strobe high
// (RULE4) External accesses always pulse the strobe
// (RULE5) External latch captures address on strobe
// (RULE6) Address low byte driven while strobe high
// (RULE7) After strobe falls, low port carries data
// (RULE8) General low port is open-drain, no pullup
// (RULE9) Memory bus mode drives both levels
// (RULE10) Low port floats after reset
// (RULE11) Second port resets to ones, weak pullup
// (RULE12) Weak-high pins also serve as inputs
// (RULE13) Written zero keeps strong pulldown on
// (RULE14) Zero-to-one write gives brief strong high
// (RULE15) Bits 0,1 serve timer 2 functions
// (RULE16) Bits 2,3 serve serial port 1
// (RULE17) Bit 4 rising, bit 5 falling interrupts
// (RULE18) Bit 6 rising, bit 7 falling interrupts
// (RULE19) Interrupt pins synchronised, edges set flags
//
// Chosen here: the plain strobed port and the register addresses.
module ppl_port_pins
(
  input  wire logic                     clock_in,                   // Twice the crystal rate
  input  wire logic                     arst_n_in,                  // Asynchronous reset, active low
  input  wire logic [7:0]               reg_addr_in,                // Register byte offset
  input  wire logic [7:0]               reg_wdata_in,               // Register write data
  input  wire logic                     reg_write_in,               // Write strobe
  input  wire logic                     reg_read_in,                // Read strobe
  output logic      [7:0]               reg_rdata_out,              // Read data, cycle after strobe
  input  wire logic                     ext_access_in,              // Core wants an external access
  input  wire ppl_pkg::ppl_ext_req_type ext_req_in,                 // Access details
  output logic                          ext_done_out,               // Pulse, access finished
  output logic      [7:0]               ext_rdata_out,              // Data of the last read
  output logic                          strobe_out,                 // Address latch strobe
  input  wire logic [7:0]               p0_in,                      // Low port pin levels
  output logic      [7:0]               p0_out,                     // Low port drive value
  output logic      [7:0]               p0_oe_out,                  // Low port drive enable
  input  wire logic [7:0]               p1_in,                      // Second port pin levels
  output logic      [7:0]               p1_out,                     // Second port strong value
  output logic      [7:0]               p1_oe_out,                  // Second port strong enable
  output logic      [7:0]               p1_pullup_out,              // Weak pullup on per pin
  input  wire logic                     timer2_ext_io_in,           // Timer 2 output onto bit 0
  output logic                          timer2_ext_io_out,          // Bit 0 level to timer 2
  output logic                          timer2_capture_trigger_out, // Bit 1 level to timer 2
  output logic                          serial1_receive_out,        // Bit 2 level to serial 1
  input  wire logic                     serial1_transmit_in,        // Serial 1 output onto bit 3
  output logic                          irq_out                     // Level interrupt
);

  // Strobe phase counter and bus sequencing
  logic [2:0]                 phase_q;        // Position in the strobe period
  logic [2:0]                 phase_d;        // Next position
  logic                       ext_act_q;      // Current period is an external access
  logic                       ext_act_d;      // Next period's access flag
  ppl_pkg::ppl_ext_req_type   ext_req_q;      // Access held for the whole period
  ppl_pkg::ppl_bus_mode_type  bus_mode_q;     // Low port use this cycle
  ppl_pkg::ppl_bus_mode_type  bus_mode_d;
  logic                       strobe_d;
  // Software state
  logic                       strobe_dis_q;   // strobe_disable_bit
  logic [7:0]                 p1_latch_q;     // Second port latch
  logic [7:0]                 p0_latch_q;     // Low port latch
  logic [3:0]                 irq_status_q;   // Sticky edge flags
  logic [3:0]                 irq_status_d;
  logic [3:0]                 irq_en_q;       // Interrupt mask
  // Pin synchronisers; stage one feeds stage two only
  logic [7:0]                 p0_sync1_q;
  logic [7:0]                 p0_sync2_q;
  logic [7:0]                 p1_sync1_q;
  logic [7:0]                 p1_sync2_q;
  logic [7:0]                 p1_prev_q;      // Last synchronised level for edge detection
  // Second port drive
  logic [7:0]                 p1_val_d;       // Level each pin should show
  logic [7:0]                 p1_val_q;       // Level applied last cycle
  logic [7:0]                 p1_boost_q;     // Second cycle of the strong-high pulse
  logic [3:0]                 edges;          // Qualifying edges this cycle

  // Rising edge of a synchronised level
  function automatic logic rise_of(input logic now_l, input logic old_l);
    rise_of = now_l & ~old_l;
  endfunction

  // Falling edge of a synchronised level
  function automatic logic fall_of(input logic now_l, input logic old_l);
    fall_of = ~now_l & old_l;
  endfunction

  // Next phase and access state; an access starts only at a period boundary
  always_comb
  begin
    phase_d   = (phase_q == ppl_pkg::PHASE_LAST) ? 3'h0 : 3'(phase_q + 3'h1);
    ext_act_d = (phase_d == 3'h0) ? ext_access_in : ext_act_q;
    // Disable only applies outside external accesses
    if (strobe_dis_q && !ext_act_d)                                       // see RULE3
    begin
      strobe_d = 1'b1;
    end
    else                                                                   // see RULE4
    begin
      strobe_d = (phase_d <= ppl_pkg::PHASE_HI_LAST);                      // see RULE1
    end
    // Low port use follows the strobe half of the period
    if (!ext_act_d)
    begin
      bus_mode_d = ppl_pkg::PPL_GPIO;
    end
    else if (phase_d <= ppl_pkg::PHASE_HI_LAST)
    begin
      bus_mode_d = ppl_pkg::PPL_ADDR;                                      // see RULE6
    end
    else if (ext_req_q.write || (phase_d == 3'h0 && ext_req_in.write))
    begin
      bus_mode_d = ppl_pkg::PPL_WDATA;                                     // see RULE7
    end
    else
    begin
      bus_mode_d = ppl_pkg::PPL_RDATA;                                     // see RULE7
    end
  end

  // Strobe timing and bus sequencing; strobe resets high
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      phase_q    <= ppl_pkg::PHASE_LAST;
      ext_act_q  <= 1'b0;
      strobe_out <= 1'b1;                                                  // see RULE2
      bus_mode_q <= ppl_pkg::PPL_GPIO;
      ext_req_q  <= '0;
    end
    else
    begin
      phase_q    <= phase_d;
      ext_act_q  <= ext_act_d;
      strobe_out <= strobe_d;
      bus_mode_q <= bus_mode_d;
      // Request is frozen for the whole period so the address cannot change mid-access
      if (phase_d == 3'h0)
      begin
        ext_req_q <= ext_req_in;
      end
    end
  end

  // Low port drive; general use is open drain, address and write data drive both levels, read data releases the port
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      p0_out    <= ppl_pkg::BYTE_ZERO;
      p0_oe_out <= ppl_pkg::BYTE_ZERO;                                     // see RULE10
    end
    else
    begin
      case (bus_mode_d)
        ppl_pkg::PPL_ADDR:
        begin
          p0_out    <= (phase_d == 3'h0) ? ext_req_in.addr_low : ext_req_q.addr_low; // see RULE6
          p0_oe_out <= ppl_pkg::BYTE_ONES;                                 // see RULE9
        end
        ppl_pkg::PPL_WDATA:
        begin
          p0_out    <= ext_req_q.wdata;
          p0_oe_out <= ppl_pkg::BYTE_ONES;                                 // see RULE9
        end
        ppl_pkg::PPL_RDATA:
        begin
          p0_out    <= ppl_pkg::BYTE_ZERO;
          p0_oe_out <= ppl_pkg::BYTE_ZERO;
        end
        default:
        begin
          // Only ever pulls low; a one floats and needs an outside pullup
          p0_out    <= ppl_pkg::BYTE_ZERO;                                 // see RULE8
          p0_oe_out <= ~p0_latch_q;                                        // see RULE8
        end
      endcase
    end
  end

  // Read data capture at the end of a read period
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ext_rdata_out <= ppl_pkg::BYTE_ZERO;
      ext_done_out  <= 1'b0;
    end
    else
    begin
      ext_done_out <= ext_act_q && (phase_q == ppl_pkg::PHASE_LAST);
      // Synchroniser delay means the device must have data on the pins two cycles before the period ends
      if (bus_mode_q == ppl_pkg::PPL_RDATA && phase_q == ppl_pkg::PHASE_LAST)
      begin
        ext_rdata_out <= p0_sync2_q;                                       // see RULE7
      end
    end
  end

  // Pin synchronisers for both ports
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      p0_sync1_q <= ppl_pkg::BYTE_ONES;
      p0_sync2_q <= ppl_pkg::BYTE_ONES;
      p1_sync1_q <= ppl_pkg::BYTE_ONES;
      p1_sync2_q <= ppl_pkg::BYTE_ONES;
      p1_prev_q  <= ppl_pkg::BYTE_ONES;
    end
    else
    begin
      p0_sync1_q <= p0_in;
      p0_sync2_q <= p0_sync1_q;
      p1_sync1_q <= p1_in;                                                 // see RULE19
      p1_sync2_q <= p1_sync1_q;                                            // see RULE12
      p1_prev_q  <= p1_sync2_q;
    end
  end

  // Second port target level, peripherals gate their output through the latch
  always_comb
  begin
    p1_val_d                           = p1_latch_q;
    p1_val_d[ppl_pkg::BIT_T2_IO]       = p1_latch_q[ppl_pkg::BIT_T2_IO] & timer2_ext_io_in;     // see RULE15
    p1_val_d[ppl_pkg::BIT_SER_TX]      = p1_latch_q[ppl_pkg::BIT_SER_TX] & serial1_transmit_in; // see RULE16
  end

  // Quasi-bidirectional drive: strong low, two-cycle strong high on a rise, then weak pullup
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      p1_val_q      <= ppl_pkg::PORT_LATCH_RST;
      p1_boost_q    <= ppl_pkg::BYTE_ZERO;
      p1_out        <= ppl_pkg::PORT_LATCH_RST;                            // see RULE11
      p1_oe_out     <= ppl_pkg::BYTE_ZERO;                                 // see RULE11
      p1_pullup_out <= ppl_pkg::PORT_LATCH_RST;                            // see RULE11
    end
    else
    begin
      p1_val_q      <= p1_val_d;
      p1_boost_q    <= p1_val_d & ~p1_val_q;
      p1_out        <= p1_val_d;
      // Boost spans one crystal period: the rising cycle plus one more
      p1_oe_out     <= ~p1_val_d | (p1_val_d & ~p1_val_q) | (p1_boost_q & p1_val_d); // see RULE13, RULE14
      p1_pullup_out <= p1_val_d;                                           // see RULE12
    end
  end

  // Alternate inputs handed to the peripherals
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      timer2_ext_io_out          <= 1'b1;
      timer2_capture_trigger_out <= 1'b1;
      serial1_receive_out        <= 1'b1;
    end
    else
    begin
      timer2_ext_io_out          <= p1_sync2_q[ppl_pkg::BIT_T2_IO];         // see RULE15
      timer2_capture_trigger_out <= p1_sync2_q[ppl_pkg::BIT_T2_TRIG];       // see RULE15
      serial1_receive_out        <= p1_sync2_q[ppl_pkg::BIT_SER_RX];        // see RULE16
    end
  end

  // Edge detection on synchronised levels, then sticky flags where set beats clear
  always_comb
  begin
    edges[0] = rise_of(p1_sync2_q[ppl_pkg::BIT_IRQ_RISE_A], p1_prev_q[ppl_pkg::BIT_IRQ_RISE_A]); // see RULE17
    edges[1] = fall_of(p1_sync2_q[ppl_pkg::BIT_IRQ_FALL_A], p1_prev_q[ppl_pkg::BIT_IRQ_FALL_A]); // see RULE17
    edges[2] = rise_of(p1_sync2_q[ppl_pkg::BIT_IRQ_RISE_B], p1_prev_q[ppl_pkg::BIT_IRQ_RISE_B]); // see RULE18
    edges[3] = fall_of(p1_sync2_q[ppl_pkg::BIT_IRQ_FALL_B], p1_prev_q[ppl_pkg::BIT_IRQ_FALL_B]); // see RULE18
    irq_status_d = irq_status_q;
    if (reg_write_in && reg_addr_in == ppl_pkg::OFS_IRQ_CLEAR)
    begin
      irq_status_d = irq_status_d & ~reg_wdata_in[3:0];
    end
    irq_status_d = irq_status_d | edges;                                   // see RULE19
  end

  // Software registers
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      strobe_dis_q <= 1'b0;
      p1_latch_q   <= ppl_pkg::PORT_LATCH_RST;
      p0_latch_q   <= ppl_pkg::PORT_LATCH_RST;
      irq_status_q <= ppl_pkg::IRQ_ZERO;
      irq_en_q     <= ppl_pkg::IRQ_ZERO;
      irq_out      <= 1'b0;
    end
    else
    begin
      irq_status_q <= irq_status_d;
      // Output from next values so the pin tracks status with no lag
      irq_out      <= |(irq_status_d & irq_en_q);
      if (reg_write_in)
      begin
        case (reg_addr_in)
          ppl_pkg::OFS_POWER_MGMT: strobe_dis_q <= reg_wdata_in[ppl_pkg::BIT_STROBE_DISABLE]; // see RULE3
          ppl_pkg::OFS_P1_LATCH:   p1_latch_q   <= reg_wdata_in;           // see RULE13
          ppl_pkg::OFS_P0_LATCH:   p0_latch_q   <= reg_wdata_in;
          ppl_pkg::OFS_IRQ_ENABLE: irq_en_q     <= reg_wdata_in[3:0];
          default:                 p0_latch_q   <= p0_latch_q;
        endcase
      end
    end
  end

  // Read data register; unmapped and write-only offsets read zero
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      reg_rdata_out <= ppl_pkg::BYTE_ZERO;
    end
    else if (reg_read_in)
    begin
      case (reg_addr_in)
        ppl_pkg::OFS_POWER_MGMT: reg_rdata_out <= {5'h00, strobe_dis_q, 2'h0};
        ppl_pkg::OFS_P1_LATCH:   reg_rdata_out <= p1_latch_q;
        ppl_pkg::OFS_P1_PINS:    reg_rdata_out <= p1_sync2_q;              // see RULE12
        ppl_pkg::OFS_P0_LATCH:   reg_rdata_out <= p0_latch_q;
        ppl_pkg::OFS_P0_PINS:    reg_rdata_out <= p0_sync2_q;
        ppl_pkg::OFS_IRQ_STATUS: reg_rdata_out <= {4'h0, irq_status_q};
        ppl_pkg::OFS_IRQ_ENABLE: reg_rdata_out <= {4'h0, irq_en_q};
        default:                 reg_rdata_out <= ppl_pkg::BYTE_ZERO;
      endcase
    end
    else
    begin
      reg_rdata_out <= ppl_pkg::BYTE_ZERO;
    end
  end

  // Checks on the driven behaviour
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!arst_n_in);

  property p_strobe_width;
    disable iff (!arst_n_in || strobe_dis_q)
    $rose(strobe_out) |-> strobe_out[*3] ##1 !strobe_out;
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("strobe width wrong"); // see RULE1

  property p_strobe_period;
    disable iff (!arst_n_in || strobe_dis_q)
    $rose(strobe_out) |-> ##8 $rose(strobe_out);
  endproperty
  a_strobe_period: assert property (p_strobe_period) else $error("strobe period wrong"); // see RULE1

  property p_strobe_hold;
    (strobe_dis_q && !ext_act_q) |=> strobe_out;
  endproperty
  a_strobe_hold: assert property (p_strobe_hold) else $error("strobe not held high"); // see RULE3

  property p_addr_drive;
    (bus_mode_q == ppl_pkg::PPL_ADDR) |-> strobe_out && p0_oe_out == 8'hFF && p0_out == ext_req_q.addr_low;
  endproperty
  a_addr_drive: assert property (p_addr_drive) else $error("address not on low port"); // see RULE6

  property p_read_release;
    (bus_mode_q == ppl_pkg::PPL_RDATA) |-> !strobe_out && p0_oe_out == 8'h00;
  endproperty
  a_read_release: assert property (p_read_release) else $error("low port not released"); // see RULE7

  property p_open_drain;
    (bus_mode_q == ppl_pkg::PPL_GPIO) |-> p0_out == 8'h00 && p0_oe_out == ~$past(p0_latch_q);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("low port not open drain"); // see RULE8

  property p_low_driven;
    ((~p1_out) & (~p1_oe_out)) == 8'h00;
  endproperty
  a_low_driven: assert property (p_low_driven) else $error("second port low not driven"); // see RULE13

  property p_boost;
    $rose(p1_out[0]) ##1 p1_out[0] ##1 p1_out[0] |-> !p1_oe_out[0] && $past(p1_oe_out[0], 2);
  endproperty
  a_boost: assert property (p_boost) else $error("strong high pulse wrong"); // see RULE14

  property p_irq_rise;
    $rose(p1_sync2_q[4]) |=> irq_status_q[0];
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("rising edge flag missed"); // see RULE17

  property p_irq_fall;
    $fell(p1_sync2_q[7]) |=> irq_status_q[3];
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("falling edge flag missed"); // see RULE18

  property p_rx_route;
    ##1 serial1_receive_out == $past(p1_sync2_q[2]);
  endproperty
  a_rx_route: assert property (p_rx_route) else $error("receive input not routed"); // see RULE16

  c_ext_read:  cover property (bus_mode_q == ppl_pkg::PPL_RDATA ##[1:8] ext_done_out);
  c_ext_write: cover property (bus_mode_q == ppl_pkg::PPL_WDATA);
  c_irq:       cover property ($rose(irq_out));
  c_hold:      cover property ((strobe_dis_q && strobe_out) [*8]);
endmodule

// ---- test/ppl_ext_mem.sv ----
// Address latch and byte memory on the far side of the low port
module ppl_ext_mem
(
  input  wire logic       clock_in,  // Bench clock
  input  wire logic       strobe_in, // Address latch strobe
  input  wire logic [7:0] p0_in,     // Device drive value
  input  wire logic [7:0] p0_oe_in,  // Device drive enable
  input  wire logic       rd_in,     // Read cycle under way
  input  wire logic       wr_in,     // Write cycle under way
  output logic      [7:0] pins_out   // Resolved low port wire
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] addr_q;      // Latched low address
  logic [7:0] mem_q [256]; // Storage
  logic       drv;         // Memory drives read data
  // Latch follows while the strobe is high and holds after the fall; it samples at the
  // clock so that an address and a strobe fall launched on one edge cannot race
  always @(posedge clock_in)
    if (strobe_in) addr_q <= pins_out;
  // Drive only when the device has let go; pullups win otherwise
  assign drv = rd_in && !strobe_in && (p0_oe_in == 8'h00);
  assign pins_out = (p0_oe_in & p0_in) | (~p0_oe_in & (drv ? mem_q[addr_q] : 8'hFF));
  // Write data captured while the strobe is low
  always @(posedge clock_in)
    if (wr_in && !strobe_in && p0_oe_in == 8'hFF) mem_q[addr_q] <= pins_out;
endmodule

// ---- test/tb_ppl_port_pins.sv ----
// Self-checking bench for the port pin and address strobe block
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb_ppl_port_pins;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, reg_wr, reg_rd, acc, done, erd_unused, strobe, t2o, t2t, srx, irq, mrd, mwr;
  logic t2i, stx; // Peripheral outputs routed onto bits 0 and 3
  logic [7:0] addr, wdata, rdata, erd, p0_pins, p0o, p0oe, p1_pins, p1o, p1oe, p1pu, den, dval;
  ppl_pkg::ppl_ext_req_type req; // External access request
  int n_mismatch, checked, lows, i;
  // Clock: 100 ns period
  always #50 clk = ~clk;
  // Second port wire: strong drive, then bench drive, then weak pullup
  assign p1_pins = (p1oe & p1o) | (~p1oe & den & dval) | (~p1oe & ~den & p1pu);
  ppl_port_pins u_ppl_port_pins (.clock_in(clk), .arst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_write_in(reg_wr), .reg_read_in(reg_rd), .reg_rdata_out(rdata), .ext_access_in(acc), .ext_req_in(req),
    .ext_done_out(done), .ext_rdata_out(erd), .strobe_out(strobe), .p0_in(p0_pins), .p0_out(p0o),
    .p0_oe_out(p0oe), .p1_in(p1_pins), .p1_out(p1o), .p1_oe_out(p1oe), .p1_pullup_out(p1pu),
    .timer2_ext_io_in(t2i), .timer2_ext_io_out(t2o), .timer2_capture_trigger_out(t2t),
    .serial1_receive_out(srx), .serial1_transmit_in(stx), .irq_out(irq));
  ppl_ext_mem u_ppl_ext_mem (.clock_in(clk), .strobe_in(strobe), .p0_in(p0o), .p0_oe_in(p0oe), .rd_in(mrd),
    .wr_in(mwr), .pins_out(p0_pins));
  // Register port cycles; read data taken in the cycle after the strobe
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) {addr, wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic bus_rd(input string n, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) {addr, reg_rd} <= {a, 1'b1};
    @(posedge clk) reg_rd <= 1'b0;
    #1 `CHK(n, e, rdata)
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Count settled samples of the strobe at one level
  task automatic run(input logic lvl, input int lim, output int c);
    c = 0;
    while (c < lim && strobe === lvl) begin c++; cyc(1); end
  endtask
  // One external access; request dropped once the address phase shows
  task automatic ext(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge clk) {req, acc, mwr, mrd} <= {w, a, d, 1'b1, w, ~w};
    k = 0;
    do begin cyc(1); k++; end while (!(strobe === 1'b1 && p0oe === 8'hFF) && k < 20);
    `CHK("addr", a, p0o)
    @(posedge clk) acc <= 1'b0;
    lows = 0;
    while (done !== 1'b1 && k < 60) begin cyc(1); k++;
      if (strobe === 1'b0) begin lows++; `CHK("data_oe", {8{w}}, p0oe) end end
    `CHK("lows", 5, lows)
    @(posedge clk) {mwr, mrd} <= 2'b00;
  endtask
  // Final verdict, also reached from the watchdog
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Watchdog: the tests need well under a tenth of this
  initial
  begin
    #2000000 n_mismatch++;
    conclude();
  end
  // Test sequence
  initial
  begin
    {clk, rst_n, reg_wr, reg_rd, acc, mrd, mwr, addr, wdata, den, dval, req} = '0;
    {n_mismatch, checked} = '0;
    {t2i, stx} = 2'b11;
    cyc(2);
    `CHK("rst_strobe", 1'b1, strobe)
    `CHK("rst_p0oe", 8'h00, p0oe)
    `CHK("rst_p1", 16'hFF00, {p1pu, p1oe})
    @(posedge clk) rst_n <= 1'b1;
    bus_rd("p1_latch", ppl_pkg::OFS_P1_LATCH, 8'hFF);
    bus_rd("unmapped", 8'h10, 8'h00);
    run(1'b1, 20, lows); run(1'b0, 20, lows); run(1'b1, 20, lows);
    `CHK("strobe_hi", 3, lows)
    run(1'b0, 20, lows);
    `CHK("strobe_lo", 5, lows)
    $display("strobe test done");
    bus_wr(ppl_pkg::OFS_POWER_MGMT, 8'h04);
    cyc(2);
    run(1'b1, 16, lows);
    `CHK("disabled", 16, lows)
    ext(1'b1, 8'h3C, 8'h5A);
    ext(1'b0, 8'h3C, 8'h00);
    `CHK("ext_rd", 8'h5A, erd)
    $display("external test done");
    bus_wr(ppl_pkg::OFS_P1_LATCH, 8'hFE);
    cyc(8);
    `CHK("p1_low", 2'b10, {p1oe[0], p1o[0]})
    bus_wr(ppl_pkg::OFS_P1_LATCH, 8'hFF);
    cyc(1);
    `CHK("boost", 2'b11, {p1oe[0], p1o[0]})
    cyc(3);
    `CHK("weak", 1'b0, p1oe[0])
    @(posedge clk) {t2i, stx} <= 2'b00;
    cyc(3);
    `CHK("alt_out", 4'b1010, {p1oe[0], p1o[0], p1oe[3], p1o[3]})
    @(posedge clk) {t2i, stx} <= 2'b11;
    cyc(4);
    $display("second port test done");
    @(posedge clk) {den, dval} <= {8'hF6, 8'hA0};
    bus_wr(ppl_pkg::OFS_IRQ_ENABLE, 8'h0F);
    cyc(6);
    bus_wr(ppl_pkg::OFS_IRQ_CLEAR, 8'h0F);
    cyc(2);
    `CHK("alt", 3'b100, {t2o, t2t, srx})
    bus_rd("p1_pins", ppl_pkg::OFS_P1_PINS, 8'hA9);
    for (i = 0; i < 4; i++) begin
      @(posedge clk) dval <= dval ^ (8'h10 << i);
      cyc(6);
      bus_rd("flag", ppl_pkg::OFS_IRQ_STATUS, 8'h01 << i);
      `CHK("irq", 1'b1, irq)
      bus_wr(ppl_pkg::OFS_IRQ_CLEAR, 8'h01 << i);
    end
    bus_wr(ppl_pkg::OFS_IRQ_ENABLE, 8'h00);
    for (i = 0; i < 2; i++) begin @(posedge clk) dval <= dval ^ 8'h10; cyc(6); end
    `CHK("masked", 1'b0, irq)
    bus_rd("rise_only", ppl_pkg::OFS_IRQ_STATUS, 8'h01);
    $display("interrupt test done");
    bus_wr(ppl_pkg::OFS_P0_LATCH, 8'h0F);
    cyc(4);
    `CHK("p0_od", 16'hF000, {p0oe, p0o})
    bus_rd("p0_pins", ppl_pkg::OFS_P0_PINS, 8'h0F);
    $display("low port test done");
    conclude();
  end
endmodule
